// *** core/pbp_pkg.sv ***
// Package for the eight-pin general-purpose port: register map, reset values, widths.
// Assumes an Avalon-MM slave with byte addresses and 32-bit data.
package pbp_pkg;
  // Register byte addresses (printed offsets are halfword aligned)
  localparam logic [15:0] PBP_DIR_OFS   = 16'hFFD4;  // Direction select, write only
  localparam logic [15:0] PBP_LATCH_OFS = 16'hFFD6;  // Output latch
  // Offsets of the control register holding selection hooks
  localparam logic [15:0] PBP_CTRL_OFS  = 16'hFFD8;  // Pattern, trigger, chip select enables
  localparam logic [15:0] PBP_RDBK_OFS  = 16'hFFDC;  // Read back of direction (diagnostic)
  // Reset values
  localparam logic [7:0]  PBP_DIR_RST   = 8'h00;
  localparam logic [7:0]  PBP_LATCH_RST = 8'h00;
  localparam logic [7:0]  PBP_PAT_RST   = 8'h00;
  // Value every bit returns when the direction register is read
  localparam logic [7:0]  PBP_DIR_READ  = 8'hFF;
  // Field positions inside the control register
  localparam int          PBP_CTRL_PAT_LSB = 0;   // Pattern enable bits 7:0
  localparam int          PBP_CTRL_TRG_BIT = 8;   // A/D trigger enable
  localparam int          PBP_CTRL_CS_BIT  = 9;   // Chip-select output enable
  // Pin positions
  localparam int          PBP_TRIG_PIN  = 7;
  localparam int          PBP_CS_PIN    = 6;
  // Operating mode in which chip select is not offered
  localparam logic [2:0]  PBP_MODE_SINGLE = 3'h7;
  // Bus answer latency in cycles for a read (registered answer)
  localparam int          PBP_RD_LAT    = 1;
  // Bus state
  typedef enum logic [0:0] {PBP_IDLE, PBP_ANSWER} pbp_bus_type;
endpackage : pbp_pkg

// *** core/pbp_pin_if.sv ***
// Interface carrying per-pin selection between the port core and its pin mux.
// Assumes one clock domain; signals are combinational from registered sources.
`timescale 1ns/100ps
`default_nettype none
interface pbp_pin_if #(parameter int W = 8);
  logic [W-1:0] dir;       // Direction bits
  logic [W-1:0] latch;     // Output latch
  logic [W-1:0] pat_en;    // Pattern output enables
  logic [W-1:0] pat_val;   // Pattern values
  logic         cs_sel;    // Chip select owns pin 6
  logic         cs_val;    // Chip select level
  logic [W-1:0] drv_val;   // Resulting drive level
  logic [W-1:0] drv_en;    // Resulting drive enable
  modport core (output dir, latch, pat_en, pat_val, cs_sel, cs_val, input drv_val, drv_en);
  modport mux  (input dir, latch, pat_en, pat_val, cs_sel, cs_val, output drv_val, drv_en);
endinterface : pbp_pin_if
`default_nettype wire

// *** core/pbp_pin_mux.sv ***
// Pin function selector: chooses latch or pattern for each pin, and chip select on pin 6.
// Assumes inputs are registered in the port core.
`timescale 1ns/100ps
`default_nettype none
module pbp_pin_mux
  import pbp_pkg::*;
#(
  parameter int W = 8
) (
  pbp_pin_if.mux pins
);
  // One selector per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    if (i == PBP_CS_PIN) begin : g_cs
      assign pins.drv_en[i]  = pins.cs_sel | pins.dir[i];
      assign pins.drv_val[i] = pins.cs_sel ? pins.cs_val :
                               (pins.pat_en[i] ? pins.pat_val[i] : pins.latch[i]);
    end else begin : g_gp
      assign pins.drv_en[i]  = pins.dir[i];
      assign pins.drv_val[i] = pins.pat_en[i] ? pins.pat_val[i] : pins.latch[i];
    end
  end
endmodule : pbp_pin_mux
`default_nettype wire

// *** core/pbp_port.sv ***
// Eight-pin general-purpose port with direction and output latch registers.
// Assumes Avalon-MM master per its spec; pin inputs synchronous to core_clk.
//
// Notes on behaviour
// - Reset or hardware standby makes pins inputs
// - Direction bit 1 output, 0 input
// - Direction register reads as all ones
// - Direction clears on reset and hardware standby, holds in software standby
// - Software standby keeps outputs driven
// - Eight-bit read/write output latch
// - Output pins read back latch value
// - Input pins read back pin level
// - Latch clears on reset and hardware standby, holds in software standby
// - Pins shared with peripheral functions
// - Chip select on pin 6 only modes 1-6
// - Unclaimed pins are plain GPIO
// - Pattern enable selects pattern over latch
// - Pin 7 feeds A/D trigger when enabled
`timescale 1ns/100ps
`default_nettype none
module pbp_port
  import pbp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [2:0]  op_mode,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]     pin_out,
  output logic [W-1:0]     pin_oe,
  input  wire logic [W-1:0] pattern_value,
  input  wire logic        chip_select_seven,
  output logic             adc_external_trigger,
  output logic             dma_request_ch0,
  output logic             dma_request_ch1,
  output logic [W-1:0]     timer_capture_in
);
  // Elaboration check: the map and pin positions assume eight pins
  if (W != 8) begin : g_bad_width
    $error("pbp_port supports only W = 8");
  end

  pbp_pin_if #(.W(W)) pins ();  // Core-to-mux carrier

  logic [W-1:0]  dir_r;        // Direction select
  logic [W-1:0]  latch_r;      // Output latch
  logic [W-1:0]  pat_en_r;     // Pattern enables
  logic          trg_en_r;     // A/D trigger enable
  logic          cs_en_r;      // Chip-select enable
  pbp_bus_type   bus_r;        // Bus answer state
  logic [31:0]   rdata_nxt;    // Read data to register
  logic [1:0]    resp_nxt;     // Response to register
  logic          hit_dir;      // Address decodes
  logic          hit_latch;
  logic          hit_ctrl;
  logic          hit_rdbk;
  logic          wr_seen;      // Write first seen while idle
  logic          wr_take;      // Write completes this edge
  logic          rd_take;      // Read accepted this edge
  logic [W-1:0]  port_read;    // Port read value

  // Address decode
  assign hit_dir   = (avs_address == PBP_DIR_OFS);
  assign hit_latch = (avs_address == PBP_LATCH_OFS);
  assign hit_ctrl  = (avs_address == PBP_CTRL_OFS);
  assign hit_rdbk  = (avs_address == PBP_RDBK_OFS);

  // Every request is first seen in idle with waitrequest high
  assign wr_seen = clk_en & avs_write & ~avs_read & (bus_r == PBP_IDLE);
  // Read data are registered when seen and stand when waitrequest drops
  assign rd_take = clk_en & avs_read & ~avs_write & (bus_r == PBP_IDLE);
  // A write lands only at the edge where the master samples waitrequest low
  assign wr_take = clk_en & avs_write & ~avs_read & (bus_r == PBP_ANSWER);

  // Direction register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dir_r <= PBP_DIR_RST;
    end else if (clk_en) begin
      if (hw_standby) begin
        dir_r <= PBP_DIR_RST;
      end else if (wr_take && hit_dir && avs_byteenable[0] && !sw_standby) begin
        dir_r <= avs_writedata[W-1:0];
      end
    end
  end

  // Output latch
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= PBP_LATCH_RST;
    end else if (clk_en) begin
      if (hw_standby) begin
        latch_r <= PBP_LATCH_RST;
      end else if (wr_take && hit_latch && avs_byteenable[0] && !sw_standby) begin
        latch_r <= avs_writedata[W-1:0];
      end
    end
  end

  // Selection hooks for shared functions
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pat_en_r <= PBP_PAT_RST;
      trg_en_r <= 1'b0;
      cs_en_r  <= 1'b0;
    end else if (clk_en) begin
      if (hw_standby) begin
        pat_en_r <= PBP_PAT_RST;
        trg_en_r <= 1'b0;
        cs_en_r  <= 1'b0;
      end else if (wr_take && hit_ctrl && !sw_standby) begin
        // Byte lane 0 holds pattern enables
        if (avs_byteenable[0]) begin
          pat_en_r <= avs_writedata[PBP_CTRL_PAT_LSB +: W];
        end
        // Byte lane 1 holds trigger and chip-select enables
        if (avs_byteenable[1]) begin
          trg_en_r <= avs_writedata[PBP_CTRL_TRG_BIT];
          cs_en_r  <= avs_writedata[PBP_CTRL_CS_BIT];
        end
      end
    end
  end

  // Signals to the pin selector
  assign pins.dir     = dir_r;
  assign pins.latch   = latch_r;
  assign pins.pat_en  = pat_en_r & dir_r;
  assign pins.pat_val = pattern_value;
  // no chip select in mode 7
  assign pins.cs_sel  = cs_en_r & (op_mode != PBP_MODE_SINGLE) & (op_mode != 3'h0);
  assign pins.cs_val  = chip_select_seven;

  pbp_pin_mux #(.W(W)) u_mux (
    .pins (pins.mux)
  );

  assign port_read = (dir_r & latch_r) | (~dir_r & pin_in);

  // Read data selection
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    resp_nxt  = 2'h0;
    if (hit_dir) begin
      rdata_nxt[W-1:0] = PBP_DIR_READ;
    end else if (hit_latch) begin
      rdata_nxt[W-1:0] = port_read;
    end else if (hit_ctrl) begin
      rdata_nxt[PBP_CTRL_PAT_LSB +: W] = pat_en_r;
      rdata_nxt[PBP_CTRL_TRG_BIT]      = trg_en_r;
      rdata_nxt[PBP_CTRL_CS_BIT]       = cs_en_r;
    end else if (hit_rdbk) begin
      rdata_nxt[W-1:0] = dir_r;
    end else begin
      // Unmapped address: slave error, data zero
      resp_nxt = 2'h2;
    end
  end

  // Bus answer: waitrequest high on read's first cycle, low when data stands
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_r <= PBP_IDLE;
    end else if (clk_en) begin
      unique case (bus_r)
        PBP_IDLE:   bus_r <= (rd_take | wr_seen) ? PBP_ANSWER : PBP_IDLE;
        PBP_ANSWER: bus_r <= PBP_IDLE;
      endcase
    end
  end

  // Registered read data and response
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if (clk_en) begin
      if (rd_take) begin
        avs_readdata <= rdata_nxt;
        avs_response <= resp_nxt;
      end else if (wr_seen) begin
        avs_response <= resp_nxt;
      end
    end
  end

  // Waitrequest: high by default, low only in the cycle in which the answer stands
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~(rd_take | wr_seen);
    end
  end

  // Pin drive registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else if (clk_en) begin
      if (hw_standby) begin
        pin_oe  <= '0;
        pin_out <= '0;
      end else if (!sw_standby) begin
        pin_oe  <= pins.drv_en;
        pin_out <= pins.drv_val;
      end
    end
  end

  // Peripheral inputs taken from the pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc_external_trigger <= 1'b0;
      dma_request_ch0      <= 1'b0;
      dma_request_ch1      <= 1'b0;
      timer_capture_in     <= '0;
    end else if (clk_en) begin
      adc_external_trigger <= trg_en_r & pin_in[PBP_TRIG_PIN];
      dma_request_ch0      <= pin_in[PBP_CS_PIN];
      dma_request_ch1      <= pin_in[PBP_TRIG_PIN];
      timer_capture_in     <= pin_in;
    end
  end

  // Assertions
  // hardware standby drives nothing
  property p_hw_stby_inputs;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_standby) |=> (pin_oe == '0 && dir_r == '0);
  endproperty
  a_hw_stby_inputs: assert property (p_hw_stby_inputs) else $error("pins not inputs in standby");

  property p_dir_write;
    @(posedge core_clk) disable iff (!nrst)
      (wr_take && hit_dir && avs_byteenable[0] && !sw_standby && !hw_standby)
      |=> (dir_r == $past(avs_writedata[W-1:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_dir_read;
    @(posedge core_clk) disable iff (!nrst)
      (rd_take && hit_dir) |=> (avs_readdata[W-1:0] == PBP_DIR_READ && !avs_waitrequest);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not all ones");

  property p_port_read;
    @(posedge core_clk) disable iff (!nrst)
      (rd_take && hit_latch) |=> (avs_readdata[W-1:0] == $past(port_read));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read source wrong");

  property p_sw_hold;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && sw_standby && !hw_standby) |=> $stable(pin_out) && $stable(pin_oe);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("drive changed in software standby");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && sw_standby && !hw_standby) |=> $stable(latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed in standby");

  // chip select absent in mode 7
  property p_cs_mode7;
    @(posedge core_clk) disable iff (!nrst)
      (op_mode == PBP_MODE_SINGLE) |-> !pins.cs_sel;
  endproperty
  a_cs_mode7: assert property (p_cs_mode7) else $error("chip select in mode 7");

  property p_trigger;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && trg_en_r) |=> (adc_external_trigger == $past(pin_in[PBP_TRIG_PIN]));
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger not passed");

  // latch write reaches pin 0 the edge after the latch loads
  sequence s_latch_wr;
    wr_take && hit_latch && avs_byteenable[0] && !sw_standby && !hw_standby;
  endsequence
  property p_latch_to_pin;
    @(posedge core_clk) disable iff (!nrst)
      s_latch_wr ##1 (clk_en && !sw_standby && !hw_standby && dir_r[0] && !pins.pat_en[0])
      |=> (pin_out[0] == latch_r[0]);
  endproperty
  a_latch_to_pin: assert property (p_latch_to_pin) else $error("latch not on pin");

  sequence s_req_seen;
    rd_take || wr_seen;
  endsequence
  property p_one_wait;
    @(posedge core_clk) disable iff (!nrst)
      s_req_seen |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not given after one wait");

  property p_oe_dir;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && !hw_standby && !sw_standby && !pins.cs_sel) |=> (pin_oe == $past(dir_r));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("enable differs from direction");

  property p_latch_write;
    @(posedge core_clk) disable iff (!nrst)
      (wr_take && hit_latch && avs_byteenable[0] && !sw_standby && !hw_standby)
      |=> (latch_r == $past(avs_writedata[W-1:0]));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  property p_pattern;
    @(posedge core_clk) disable iff (!nrst)
      (clk_en && !hw_standby && !sw_standby && pins.pat_en[0])
      |=> (pin_out[0] == $past(pattern_value[0]));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern value not driven");
endmodule : pbp_port
`default_nettype wire

// *** dv/pbp_board.sv ***
// Board model for the eight port pins: pull-less lines driven from outside.
// Assumes the bench supplies the external level of every released pin.
`timescale 1ns/100ps
`default_nettype none
module pbp_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_in
);
  // A driven pin shows its own drive, a released pin the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : pbp_board
`default_nettype wire

// *** dv/test_eight_bit_io_port_b.sv ***
// Self-checking bench for the eight-pin port with a queue-free integer model.
// Assumes the port holds waitrequest high until its answer stands.
`timescale 1ns/100ps
`default_nettype none
module test_eight_bit_io_port_b;
  import pbp_pkg::*;
  logic        core_clk, nrst, hw_sb, sw_sb, cs_lvl;  // Clock, reset, modes
  logic [2:0]  op_mode;                               // Operating mode
  logic [15:0] avs_address;                           // Bus address
  logic        avs_read, avs_write, avs_waitrequest;  // Bus strobes
  logic [31:0] avs_writedata, avs_readdata, seed;     // Bus data, random state
  logic [1:0]  avs_response;                          // Bus response
  logic [7:0]  pin_in, pin_out, pin_oe, ext_val, pat_val; // Pins
  logic        adc_trg;                               // Trigger output
  logic        dma0, dma1;                            // DMA request copies
  logic [7:0]  tmr;                                   // Timer input copies
  int          n_errors, n_checks, i, dir_m, lat_m, ctl_m, pv_m, cs_m, ext_m; // Model
  pbp_port dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .hw_standby(hw_sb),
    .sw_standby(sw_sb), .op_mode(op_mode), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pattern_value(pat_val), .chip_select_seven(cs_lvl), .adc_external_trigger(adc_trg),
    .dma_request_ch0(dma0), .dma_request_ch1(dma1), .timer_capture_in(tmr));
  pbp_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));
  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Next random word from the shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Verdict and end of run
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Compare one result and count it
  task cmp(input logic [31:0] g, input logic [31:0] e, input string w);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : cmp
  // One bus transfer; held until waitrequest is sampled low
  task bus(input bit wr, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // Held until waitrequest is sampled low; only the limit ends a wait early
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      cmp(1, 0, "bus hang");
      end_sim;
    end
    rd = avs_readdata;
    rs = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  // Register write; the model ignores writes while in either standby
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic [1:0]  s;
    bus(1, a, d, r, s);
    if (!sw_sb && !hw_sb && a == PBP_DIR_OFS) dir_m = d[7:0];
    if (!sw_sb && !hw_sb && a == PBP_LATCH_OFS) lat_m = d[7:0];
    if (!sw_sb && !hw_sb && a == PBP_CTRL_OFS) ctl_m = d[9:0];
  endtask : wr
  // Register read compared with the model
  task rdchk(input logic [15:0] a);
    logic [31:0] r;
    logic [1:0]  s;
    int          ex;
    int          ok;
    ex = (lat_m & dir_m) | (ext_m & ~dir_m);
    ok = (a == PBP_DIR_OFS || a == PBP_LATCH_OFS || a == PBP_CTRL_OFS);
    bus(0, a, 0, r, s);
    if (a == PBP_DIR_OFS) cmp(r[7:0], PBP_DIR_READ, "dir read");
    else if (a == PBP_LATCH_OFS) cmp(r[7:0], ex, "latch read");
    else if (a == PBP_CTRL_OFS) cmp(r[9:0], ctl_m[9:0], "ctrl read");
    cmp(s, ok ? 0 : 2, "response");
  endtask : rdchk
  // New pattern, chip-select and board levels; pattern and select freeze in software standby
  task drive(input logic [7:0] p, input logic c, input logic [7:0] e);
    pat_val <= p;
    cs_lvl  <= c;
    ext_val <= e;
    ext_m = e;
    if (!sw_sb) begin
      pv_m = p;
      cs_m = c;
    end
  endtask : drive
  // Pin drive, enable and trigger compared with the model
  task pinchk;
    int pat, drv, lvl, om;
    repeat (4) @(posedge core_clk);
    pat = ctl_m[7:0] & dir_m;
    drv = (pat & pv_m) | (~pat & lat_m);
    om  = dir_m;
    // Chip select owns pin 6 only in modes 1 to 6
    if (ctl_m[9] && op_mode != 3'h0 && op_mode != PBP_MODE_SINGLE) begin
      drv = (drv & 8'hBF) | (cs_m << 6);
      om  = om | 8'h40;
    end
    // Line level: own drive where enabled, board level elsewhere
    lvl = (om & drv) | (~om & ext_m);
    // Pin-fed outputs sit at zero while reset is applied
    if (!nrst) lvl = 0;
    cmp(pin_out & om[7:0], drv[7:0] & om[7:0], "pin drive");
    cmp(pin_oe, om[7:0], "pin enable");
    cmp(adc_trg, ctl_m[8] & lvl[7], "trigger");
    cmp(dma0, lvl[6], "dma request 0");
    cmp(dma1, lvl[7], "dma request 1");
    cmp(tmr, lvl[7:0], "timer inputs");
  endtask : pinchk
  // Model back to reset values
  task clr;
    dir_m = 0;
    lat_m = 0;
    ctl_m = 0;
  endtask : clr
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    nrst          = 1'b0;
    hw_sb         = 1'b0;
    sw_sb         = 1'b0;
    cs_lvl        = 1'b0;
    op_mode       = 3'h1;
    avs_address   = 16'h0000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    ext_val       = 8'h00;
    pat_val       = 8'h00;
    seed          = 32'h01D0_5926;
    n_errors      = 0;
    n_checks      = 0;
    pv_m          = 0;
    cs_m          = 0;
    ext_m         = 0;
    clr;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    pinchk;
    rdchk(PBP_DIR_OFS);
    seed = lfsr(seed);
    drive(8'h00, 1'b0, seed[7:0]);
    rdchk(PBP_LATCH_OFS);
    // Plain port use with random direction and data
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(PBP_DIR_OFS, {24'h00_0000, seed[15:8]});
      wr(PBP_LATCH_OFS, {24'h00_0000, seed[23:16]});
      drive(seed[7:0], 1'b0, seed[31:24]);
      pinchk;
      rdchk(PBP_LATCH_OFS);
      rdchk(PBP_DIR_OFS);
    end
    // Pattern outputs and trigger enable on and off
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      // Pattern pins get their direction bits set first
      wr(PBP_DIR_OFS, {24'h00_0000, seed[15:8]});
      wr(PBP_CTRL_OFS, {23'h00_0000, i[0], seed[7:0] & seed[15:8]});
      drive(seed[23:16], 1'b0, seed[31:24]);
      pinchk;
      rdchk(PBP_LATCH_OFS);
      rdchk(PBP_CTRL_OFS);
    end
    // Chip select across every operating mode
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      op_mode <= i[2:0];
      wr(PBP_CTRL_OFS, 32'h0000_0200);
      drive(seed[7:0], seed[8], ext_m[7:0]);
      pinchk;
    end
    wr(PBP_CTRL_OFS, 32'h0000_0000);
    rdchk(16'hFF00);
    // Software standby keeps registers and drives
    sw_sb <= 1'b1;
    wr(PBP_LATCH_OFS, ~lat_m);
    wr(PBP_DIR_OFS, ~dir_m);
    pinchk;
    sw_sb <= 1'b0;
    rdchk(PBP_LATCH_OFS);
    // Hardware standby clears direction, latch, control and drives
    hw_sb <= 1'b1;
    clr;
    pinchk;
    hw_sb <= 1'b0;
    wr(PBP_DIR_OFS, 32'h0000_00FF);
    rdchk(PBP_LATCH_OFS);
    // Reset in mid-run
    wr(PBP_LATCH_OFS, 32'h0000_005A);
    @(posedge core_clk);
    nrst <= 1'b0;
    clr;
    pinchk;
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    wr(PBP_DIR_OFS, 32'h0000_00FF);
    rdchk(PBP_LATCH_OFS);
    end_sim;
  end
endmodule : test_eight_bit_io_port_b
`default_nettype wire
